// ===== pkg/imh_regs.svh
// Register map, field positions and timing counts of the integrity monitor.
//
// Summary of operation
// (R1) Bus master fetches descriptors from memory and hashes the regions they define.
// (R2) Monitoring compares each hash with the stored digest; mismatch raises interrupt.
// (R3) At most four regions, possibly non-contiguous, each known by region index.
// (R4) Linked secondary descriptors gather several memory blocks into one region hash.
// (R5) Hash core offers SHA-1, SHA-224 and SHA-256, chosen per region.
// (R6) SHA-1 period is 85 or 209 cycles plus 2 start cycles.
// (R7) SHA-224/256 period is 72 or 194 cycles plus 2 start cycles.
// (R8) Per-region configuration picks short or long processing period.
// (R9) Digest-done flag sets when digest is available, unless disabled.
// (R10) Region-end flag sets at the same moment, unless disabled.
// (R11) Interrupt needs the enable bit and the flag enabled for that region.
// (R12) Automatic-mode bit starts a digest pass followed by continuous monitoring.
// (R13) Automatic mode first walks the main list once, write-back on, no end.
// (R14) Wrap then enters monitoring: write-back off, end cleared, software bits ignored.
// (R15) One contiguous region: one descriptor, write-back, end set, no next pointer.
// (R16) Non-contiguous region: next pointer names a secondary list of blocks.
// (R17) Descriptors, data and digests all move over the own AHB master port.
// (R18) Without end, continue at next descriptor, or list start when wrap set.
`ifndef IMH_REGS_SVH
`define IMH_REGS_SVH
`define IMH_CFG_OFS 12'h000
`define IMH_DSCR_OFS 12'h004
`define IMH_HASH_OFS 12'h008
`define IMH_STAT_OFS 12'h00C
`define IMH_MASK_OFS 12'h010
`define IMH_STATE_OFS 12'h014
`define IMH_CFG_EN 0
`define IMH_CFG_AUTO 1
`define IMH_DC_WRAP 0
`define IMH_DC_EOM 1
`define IMH_DC_WBD 2
`define IMH_DC_DDD 3
`define IMH_DC_EFD 4
`define IMH_DC_LONG 5
`define IMH_DC_ALGO 7:6
`define IMH_ST_DONE_LSB 0
`define IMH_ST_END_LSB 4
`define IMH_ST_MIS_LSB 8
`define IMH_ST_BERR 12
`define IMH_STAT_RST 13'h0000
`define IMH_DESC_LAST 5'h03
`define IMH_BLK_LAST 5'h0F
`define IMH_DESC_STEP 32'h0000_0010
`define IMH_BLK_STEP 32'h0000_0040
`define IMH_SHA1_LAST 5'h04
`define IMH_SHA224_LAST 5'h06
`define IMH_SHA256_LAST 5'h07
`define IMH_LAST_RGN 2'h3
`define IMH_HTRANS_IDLE 2'h0
`define IMH_HTRANS_NSEQ 2'h2
`define IMH_HSIZE_WORD 3'h2
// Processing periods in clock cycles: 85, 209, 72, 194 and 2 for sync.
`define IMH_SYNC 8'h02
`define IMH_SHA1_SHORT 8'h55
`define IMH_SHA1_LONG 8'hD1
`define IMH_SHA2_SHORT 8'h48
`define IMH_SHA2_LONG 8'hC2
`define IMH_SHA1_ROUNDS 8'h50
`define IMH_SHA2_ROUNDS 8'h40
`endif

// ===== pkg/imh_pkg.sv
// Types shared by the integrity monitor and its hash core.
`default_nettype none
package imh_pkg;
	typedef enum logic [1:0] {
		IMH_SHA1   = 2'h0,
		IMH_SHA256 = 2'h1,
		IMH_SHA224 = 2'h2
	} imh_algo_type;
	typedef enum logic [2:0] {
		IMH_IDLE   = 3'h0,
		IMH_DESC   = 3'h1,
		IMH_BLOCK  = 3'h2,
		IMH_HASH   = 3'h3,
		IMH_DIGEST = 3'h4,
		IMH_NEXT   = 3'h5
	} imh_fsm_type;
	typedef enum logic [1:0] {
		IMH_BUS_IDLE = 2'h0,
		IMH_BUS_ADDR = 2'h1,
		IMH_BUS_DATA = 2'h2
	} imh_bus_type;
	typedef struct packed {
		logic [15:0][31:0] w;
		logic [7:0][31:0]  h;
		logic [7:0][31:0]  v;
		logic [7:0]        cnt;
		logic              busy;
		logic              done;
	} imh_core_type;
	typedef struct packed {
		imh_fsm_type fsm;
		imh_bus_type bus;
		logic        en;
		logic        auto_mode;
		logic        mon;
		logic        first;
		logic        mis;
		logic [31:0] dscr;
		logic [31:0] hash;
		logic [31:0] mptr;
		logic [31:0] fptr;
		logic [31:0] dadr;
		logic [31:0] dnext;
		logic [7:0]  dcfg;
		logic [15:0] dcnt;
		logic [4:0]  idx;
		logic [1:0]  rgn;
		logic [12:0] stat;
		logic [12:0] mask;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic [31:0] haddr;
		logic [31:0] hwdata;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        wr_en;
		logic [3:0]  wr_idx;
		logic [31:0] wr_data;
		logic        start;
		logic        init;
	} imh_state_type;
endpackage
`default_nettype wire

// ===== hw/imh_sha_core.sv
// Iterative SHA-1 / SHA-224 / SHA-256 core with a paced processing period.
`timescale 1ns/1ps
`default_nettype none
`include "imh_regs.svh"
module imh_sha_core
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Block control
	input  wire logic                   start,
	input  wire logic                   init,
	input  wire imh_pkg::imh_algo_type  algo,
	input  wire logic                   long_per,
	// Message word load
	input  wire logic                   wr_en,
	input  wire logic [3:0]             wr_idx,
	input  wire logic [31:0]            wr_data,
	// Result
	output logic                        done,
	output logic [7:0][31:0]            digest
);
	localparam logic [7:0][31:0] IV1 = {96'h0, 32'hC3D2E1F0, 32'h10325476,
		32'h98BADCFE, 32'hEFCDAB89, 32'h67452301};
	localparam logic [7:0][31:0] IV224 = {32'hBEFA4FA4, 32'h64F98FA7,
		32'h68581511, 32'hFFC00B31, 32'hF70E5939, 32'h3070DD17,
		32'h367CD507, 32'hC1059ED8};
	localparam logic [7:0][31:0] IV256 = {32'h5BE0CD19, 32'h1F83D9AB,
		32'h9B05688C, 32'h510E527F, 32'hA54FF53A, 32'h3C6EF372,
		32'hBB67AE85, 32'h6A09E667};
	localparam logic [31:0] K [64] = '{
		32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5,
		32'h3956C25B, 32'h59F111F1, 32'h923F82A4, 32'hAB1C5ED5,
		32'hD807AA98, 32'h12835B01, 32'h243185BE, 32'h550C7DC3,
		32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7, 32'hC19BF174,
		32'hE49B69C1, 32'hEFBE4786, 32'h0FC19DC6, 32'h240CA1CC,
		32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA,
		32'h983E5152, 32'hA831C66D, 32'hB00327C8, 32'hBF597FC7,
		32'hC6E00BF3, 32'hD5A79147, 32'h06CA6351, 32'h14292967,
		32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC, 32'h53380D13,
		32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85,
		32'hA2BFE8A1, 32'hA81A664B, 32'hC24B8B70, 32'hC76C51A3,
		32'hD192E819, 32'hD6990624, 32'hF40E3585, 32'h106AA070,
		32'h19A4C116, 32'h1E376C08, 32'h2748774C, 32'h34B0BCB5,
		32'h391C0CB3, 32'h4ED8AA4A, 32'h5B9CCA4F, 32'h682E6FF3,
		32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
		32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2};

	function automatic logic [31:0] ror(input logic [31:0] x, input int n);
		return (x >> n) | (x << (32 - n));
	endfunction

	imh_pkg::imh_core_type s;
	imh_pkg::imh_core_type next_s;
	logic [7:0]            r;
	logic [7:0]            nr;
	logic [7:0]            per;
	logic [31:0]           f;
	logic [31:0]           t1;
	logic [31:0]           t2;
	logic [31:0]           nw;
	logic [7:0][31:0]      iv;
	logic                  sha1;

	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		sha1 = algo == imh_pkg::IMH_SHA1;
		r = s.cnt - `IMH_SYNC;
		nr = sha1 ? `IMH_SHA1_ROUNDS : `IMH_SHA2_ROUNDS;
		// (R6) (R7) (R8) period by algorithm
		if (sha1)
			per = long_per ? `IMH_SHA1_LONG : `IMH_SHA1_SHORT;
		else
			per = long_per ? `IMH_SHA2_LONG : `IMH_SHA2_SHORT;
		iv = sha1 ? IV1 : (algo == imh_pkg::IMH_SHA224 ? IV224 : IV256);
		f = 32'h0;
		t1 = 32'h0;
		t2 = 32'h0;
		nw = 32'h0;
		if (wr_en)
			next_s.w[wr_idx] = wr_data;
		if (start)
		begin
			next_s.busy = 1'b1;
			next_s.cnt = 8'h00;
			next_s.h = init ? iv : s.h;
			next_s.v = init ? iv : s.h;
		end
		else if (s.busy)
		begin
			next_s.cnt = s.cnt + 8'h01;
			// (R5) one round per cycle
			if (s.cnt >= `IMH_SYNC && r < nr)
			begin
				if (sha1)
				begin
					nw = ror(s.w[13] ^ s.w[8] ^ s.w[2] ^ s.w[0], 31);
					if (r < 8'd20)
						f = ((s.v[1] & s.v[2]) | (~s.v[1] & s.v[3])) + 32'h5A827999;
					else if (r < 8'd40)
						f = (s.v[1] ^ s.v[2] ^ s.v[3]) + 32'h6ED9EBA1;
					else if (r < 8'd60)
						f = ((s.v[1] & s.v[2]) | (s.v[1] & s.v[3])
							| (s.v[2] & s.v[3])) + 32'h8F1BBCDC;
					else
						f = (s.v[1] ^ s.v[2] ^ s.v[3]) + 32'hCA62C1D6;
					t1 = ror(s.v[0], 27) + f + s.v[4] + s.w[0];
					next_s.v = {96'h0, s.v[3], s.v[2], ror(s.v[1], 2), s.v[0], t1};
				end
				else
				begin
					nw = (ror(s.w[14], 17) ^ ror(s.w[14], 19) ^ (s.w[14] >> 10))
						+ s.w[9] + s.w[0]
						+ (ror(s.w[1], 7) ^ ror(s.w[1], 18) ^ (s.w[1] >> 3));
					t1 = s.v[7] + (ror(s.v[4], 6) ^ ror(s.v[4], 11) ^ ror(s.v[4], 25))
						+ ((s.v[4] & s.v[5]) ^ (~s.v[4] & s.v[6]))
						+ K[r[5:0]] + s.w[0];
					t2 = (ror(s.v[0], 2) ^ ror(s.v[0], 13) ^ ror(s.v[0], 22))
						+ ((s.v[0] & s.v[1]) ^ (s.v[0] & s.v[2]) ^ (s.v[1] & s.v[2]));
					next_s.v = {s.v[6:4], s.v[3] + t1, s.v[2:0], t1 + t2};
				end
				next_s.w = {nw, s.w[15:1]};
			end
			if (s.cnt >= `IMH_SYNC && r == nr)
				for (int i = 0; i < 8; i++)
					next_s.h[i] = s.h[i] + s.v[i];
			if (s.cnt == `IMH_SYNC + per - 8'h01)
			begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign done = s.done;
	assign digest = s.h;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sha1_short_a: assert property ( // (R6)
		start && algo == imh_pkg::IMH_SHA1 && !long_per
		|-> ##1 (!done)[*8] ##80 done)
		else $error("SHA-1 short period not 85 plus 2 cycles");
	sha2_long_a: assert property ( // (R7)
		start && algo == imh_pkg::IMH_SHA256 && long_per
		|-> ##196 !done ##1 done)
		else $error("SHA-256 long period not 194 plus 2 cycles");
endmodule
`default_nettype wire

// ===== hw/imh_monitor.sv
// Integrity monitor: APB registers, descriptor walker and AHB master.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "imh_regs.svh"
module imh_monitor
(
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// AHB master
	output logic [31:0]      HADDR,
	output logic [1:0]       HTRANS,
	output logic             HWRITE,
	output logic [2:0]       HSIZE,
	output logic [31:0]      HWDATA,
	input  wire logic [31:0] HRDATA,
	input  wire logic        HREADY,
	input  wire logic        HRESP,
	// Interrupt
	output logic             IRQ
);
	imh_pkg::imh_state_type s;
	imh_pkg::imh_state_type next_s;
	logic                   core_done;
	logic [7:0][31:0]       digest;
	logic                   setup;
	logic                   acc;
	logic                   ack;
	logic                   berr;
	logic                   want;
	logic                   wb;
	logic                   end_of_monitoring;
	logic                   last;
	logic [31:0]            addr;
	logic [4:0]             dlast;
	imh_pkg::imh_algo_type  algo;

	imh_sha_core u_core
	(
		.clk      (CLK_SYS),
		.rst      (RST),
		.start    (s.start),
		.init     (s.init),
		.algo     (algo),
		.long_per (s.dcfg[`IMH_DC_LONG]),
		.wr_en    (s.wr_en),
		.wr_idx   (s.wr_idx),
		.wr_data  (s.wr_data),
		.done     (core_done),
		.digest   (digest)
	);

	always_comb
	begin
		next_s = s;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.wr_en = 1'b0;
		next_s.start = 1'b0;
		algo = imh_pkg::imh_algo_type'(s.dcfg[`IMH_DC_ALGO]);
		setup = PSEL && !PENABLE;
		acc = PSEL && PENABLE && s.pready;
		ack = 1'b0;
		berr = 1'b0;
		want = 1'b0;
		addr = 32'h0;
		// (R13) (R14) automatic mode forces the write-back and end bits
		wb = !s.mon && (s.auto_mode || !s.dcfg[`IMH_DC_WBD]);
		end_of_monitoring = !s.auto_mode && s.dcfg[`IMH_DC_EOM];
		case (algo)
			imh_pkg::IMH_SHA1:   dlast = `IMH_SHA1_LAST;
			imh_pkg::IMH_SHA224: dlast = `IMH_SHA224_LAST;
			default:             dlast = `IMH_SHA256_LAST;
		endcase
		last = s.idx == dlast;

		// ---------------------------------------------------------------
		// Register access
		// ---------------------------------------------------------------
		if (setup)
		begin
			next_s.pready = 1'b1;
			next_s.prdata = 32'h0;
			case (PADDR)
				`IMH_CFG_OFS:
				begin
					next_s.prdata[`IMH_CFG_EN] = s.en;
					next_s.prdata[`IMH_CFG_AUTO] = s.auto_mode;
				end
				`IMH_DSCR_OFS:  next_s.prdata = s.dscr;
				`IMH_HASH_OFS:  next_s.prdata = s.hash;
				`IMH_STAT_OFS:  next_s.prdata[12:0] = s.stat;
				`IMH_MASK_OFS:  next_s.prdata[12:0] = s.mask;
				`IMH_STATE_OFS: next_s.prdata[5:0] = {s.fsm, s.mon, s.rgn};
				default:        next_s.pslverr = 1'b1;
			endcase
		end
		if (acc && PWRITE && !s.pslverr)
		begin
			case (PADDR)
				`IMH_CFG_OFS:
				begin
					// (R12) automatic mode starts from an idle engine
					if (PWDATA[`IMH_CFG_EN] && s.fsm == imh_pkg::IMH_IDLE)
					begin
						next_s.en = 1'b1;
						next_s.auto_mode = PWDATA[`IMH_CFG_AUTO];
						next_s.fsm = imh_pkg::IMH_DESC;
						next_s.mptr = s.dscr;
						next_s.fptr = s.dscr;
						next_s.rgn = 2'h0;
						next_s.mon = 1'b0;
						next_s.first = 1'b1;
						next_s.idx = 5'h00;
					end
					else if (!PWDATA[`IMH_CFG_EN])
						next_s.en = 1'b0;
				end
				`IMH_DSCR_OFS: next_s.dscr = PWDATA;
				`IMH_HASH_OFS: next_s.hash = PWDATA;
				`IMH_MASK_OFS: next_s.mask = PWDATA[12:0];
				default:       next_s.en = s.en;
			endcase
		end
		// Only bits that were returned are cleared, so a flag raised
		// during the access survives the read.
		if (acc && !PWRITE && PADDR == `IMH_STAT_OFS && !s.pslverr)
			next_s.stat = s.stat & ~s.prdata[12:0];

		// ---------------------------------------------------------------
		// AHB master phases
		// ---------------------------------------------------------------
		if (s.bus == imh_pkg::IMH_BUS_ADDR && HREADY)
		begin
			next_s.bus = imh_pkg::IMH_BUS_DATA;
			next_s.htrans = `IMH_HTRANS_IDLE;
			next_s.hwrite = 1'b0;
		end
		if (s.bus == imh_pkg::IMH_BUS_DATA && HREADY)
		begin
			next_s.bus = imh_pkg::IMH_BUS_IDLE;
			ack = !HRESP;
			berr = HRESP;
		end

		// ---------------------------------------------------------------
		// Descriptor walker
		// ---------------------------------------------------------------
		case (s.fsm)
			imh_pkg::IMH_IDLE:
				want = 1'b0;
			// (R1) (R4) (R16) main and secondary descriptors
			imh_pkg::IMH_DESC:
			begin
				want = 1'b1;
				addr = s.fptr + {25'h0, s.idx, 2'h0};
				if (ack)
				begin
					next_s.idx = s.idx + 5'h01;
					case (s.idx[1:0])
						2'h0: next_s.dadr = HRDATA;
						2'h1: next_s.dcfg = s.fptr == s.mptr ? HRDATA[7:0] : s.dcfg;
						2'h2: next_s.dcnt = HRDATA[15:0];
						default: next_s.dnext = HRDATA;
					endcase
					if (s.idx == `IMH_DESC_LAST)
					begin
						next_s.idx = 5'h00;
						next_s.fsm = imh_pkg::IMH_BLOCK;
					end
				end
			end
			imh_pkg::IMH_BLOCK:
			begin
				want = 1'b1;
				addr = s.dadr + {25'h0, s.idx, 2'h0};
				if (ack)
				begin
					next_s.wr_en = 1'b1;
					next_s.wr_idx = s.idx[3:0];
					next_s.wr_data = HRDATA;
					next_s.idx = s.idx + 5'h01;
					if (s.idx == `IMH_BLK_LAST)
					begin
						next_s.idx = 5'h00;
						next_s.start = 1'b1;
						next_s.init = s.first;
						next_s.first = 1'b0;
						next_s.dadr = s.dadr + `IMH_BLK_STEP;
						next_s.fsm = imh_pkg::IMH_HASH;
					end
				end
			end
			imh_pkg::IMH_HASH:
				if (core_done)
				begin
					if (s.dcnt != 16'h0000)
					begin
						next_s.dcnt = s.dcnt - 16'h0001;
						next_s.fsm = imh_pkg::IMH_BLOCK;
					end
					else if (s.dnext != 32'h0)
					begin
						// (R4) follow the secondary list
						next_s.fptr = s.dnext;
						next_s.fsm = imh_pkg::IMH_DESC;
					end
					else
					begin
						next_s.mis = 1'b0;
						next_s.fsm = imh_pkg::IMH_DIGEST;
					end
				end
			imh_pkg::IMH_DIGEST:
			begin
				want = 1'b1;
				addr = s.hash + {24'h0, s.rgn, 1'b0, s.idx[2:0], 2'h0};
				if (ack)
				begin
					// (R2) compare against the stored digest
					next_s.mis = s.mis || (!wb && HRDATA != digest[s.idx[2:0]]);
					next_s.idx = s.idx + 5'h01;
					if (last)
					begin
						next_s.idx = 5'h00;
						next_s.fsm = imh_pkg::IMH_NEXT;
						// (R9) digest available
						if (!s.dcfg[`IMH_DC_DDD])
							next_s.stat[`IMH_ST_DONE_LSB + s.rgn] = 1'b1;
						// (R10) region end
						if (!s.dcfg[`IMH_DC_EFD])
							next_s.stat[`IMH_ST_END_LSB + s.rgn] = 1'b1;
						if (next_s.mis)
							next_s.stat[`IMH_ST_MIS_LSB + s.rgn] = 1'b1;
					end
				end
			end
			imh_pkg::IMH_NEXT:
			begin
				next_s.first = 1'b1;
				next_s.idx = 5'h00;
				// (R15) (R18) stop, wrap or advance
				if (end_of_monitoring || !s.en)
				begin
					next_s.en = 1'b0;
					next_s.fsm = imh_pkg::IMH_IDLE;
				end
				// (R3) no more than four regions per list
				else if (s.dcfg[`IMH_DC_WRAP] || s.rgn == `IMH_LAST_RGN)
				begin
					next_s.rgn = 2'h0;
					next_s.mptr = s.dscr;
					next_s.fptr = s.dscr;
					next_s.mon = s.mon || s.auto_mode;
					next_s.fsm = imh_pkg::IMH_DESC;
				end
				else
				begin
					next_s.rgn = s.rgn + 2'h1;
					next_s.mptr = s.mptr + `IMH_DESC_STEP;
					next_s.fptr = s.mptr + `IMH_DESC_STEP;
					next_s.fsm = imh_pkg::IMH_DESC;
				end
			end
			default:
				next_s.fsm = imh_pkg::IMH_IDLE;
		endcase

		// (R17) every memory access goes out on the AHB master
		if (want && s.bus == imh_pkg::IMH_BUS_IDLE)
		begin
			next_s.bus = imh_pkg::IMH_BUS_ADDR;
			next_s.htrans = `IMH_HTRANS_NSEQ;
			next_s.haddr = addr;
			next_s.hwrite = s.fsm == imh_pkg::IMH_DIGEST && wb;
			next_s.hwdata = digest[s.idx[2:0]];
		end
		if (berr)
		begin
			next_s.stat[`IMH_ST_BERR] = 1'b1;
			next_s.en = 1'b0;
			next_s.fsm = imh_pkg::IMH_IDLE;
		end
		// (R11) interrupt only for enabled flags
		next_s.irq = |(next_s.stat & next_s.mask);
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			s <= '0;
			s.stat <= `IMH_STAT_RST;
			s.hsize <= `IMH_HSIZE_WORD;
		end
		else
			s <= next_s;
	end

	assign PRDATA = s.prdata;
	assign PREADY = s.pready;
	assign PSLVERR = s.pslverr;
	assign HADDR = s.haddr;
	assign HTRANS = s.htrans;
	assign HWRITE = s.hwrite;
	assign HSIZE = s.hsize;
	assign HWDATA = s.hwdata;
	assign IRQ = s.irq;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	apb_ready_a: assert property (
		PSEL && !PENABLE |=> PREADY)
		else $error("APB access phase not answered at once");
	ahb_hold_a: assert property ( // (R17)
		s.bus == imh_pkg::IMH_BUS_DATA && !HREADY
		|=> HTRANS == `IMH_HTRANS_IDLE && $stable(HADDR) && $stable(HWDATA))
		else $error("AHB transfer changed during wait state");
	mon_nowrite_a: assert property ( // (R14)
		s.mon |-> !(HWRITE && HTRANS == `IMH_HTRANS_NSEQ))
		else $error("Digest written while monitoring");
	eom_stop_a: assert property ( // (R15)
		s.fsm == imh_pkg::IMH_NEXT && end_of_monitoring
		|=> s.fsm == imh_pkg::IMH_IDLE && !s.en)
		else $error("Engine did not stop at end of monitoring");
	rgn_wrap_a: assert property ( // (R3)
		s.fsm == imh_pkg::IMH_NEXT && s.rgn == `IMH_LAST_RGN && s.en && !end_of_monitoring
		|=> s.rgn == 2'h0 && s.mptr == $past(s.dscr))
		else $error("Region index passed four");
	irq_gate_a: assert property ( // (R11)
		IRQ == |(s.stat & s.mask))
		else $error("Interrupt level does not follow enabled flags");
	done_flag_a: assert property ( // (R9)
		s.fsm == imh_pkg::IMH_DIGEST && ack && last
		&& !s.dcfg[`IMH_DC_DDD] && !berr
		|=> s.stat[`IMH_ST_DONE_LSB + $past(s.rgn)] ##1 IRQ
		|| !s.mask[`IMH_ST_DONE_LSB + $past(s.rgn, 2)])
		else $error("Digest-done flag or interrupt missing");
endmodule
`default_nettype wire

// ===== verif/imh_ahb_mem.sv
// AHB memory model that stands in for system memory.
`timescale 1ns/1ps
`default_nettype none
module imh_ahb_mem
(
	// Bus side
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hready,
	output logic             hresp,
	// Bench controls
	input  wire logic        slow,
	input  wire logic [31:0] err_addr
);
	logic [31:0] mem [0:1023];
	logic [31:0] da;
	logic        dph;
	logic        dwr;
	logic [1:0]  wt;
	int          writes = 0;
	assign hready = !dph || wt == 2'h0;
	assign hresp  = dph && da == err_addr;
	// Idle read bus shows the inverse, so a stale sample never passes.
	assign hrdata = dph ? mem[da[11:2]] : ~mem[da[11:2]];
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dph <= 1'b0;
			wt  <= 2'h0;
			da  <= 32'h0;
		end
		else if (dph && wt != 2'h0)
			wt <= wt - 2'h1;
		else
		begin
			if (dph && dwr && !hresp)
			begin
				mem[da[11:2]] <= hwdata;
				writes <= writes + 1;
			end
			dph <= htrans == 2'h2;
			da  <= haddr;
			dwr <= hwrite;
			// An error answer takes two cycles, four when slow is set, the last one ready.
			wt  <= {slow, haddr == err_addr};
		end
	end
endmodule
`default_nettype wire

// ===== verif/imh_monitor_tb.sv
// Self-checking bench of the integrity monitor against a memory model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module imh_monitor_tb;
	logic                   CLK_SYS = 1'b0;
	logic                   RST = 1'b1;
	logic                   PSEL = 1'b0;
	logic                   PENABLE = 1'b0;
	logic                   PWRITE = 1'b0;
	logic [11:0]            PADDR = 12'h000;
	logic [31:0]            PWDATA = 32'h0;
	logic [31:0]            PRDATA, HADDR, HWDATA, HRDATA;
	logic [1:0]             HTRANS;
	logic [2:0]             HSIZE;
	logic                   PREADY, PSLVERR, HWRITE, HREADY, HRESP, IRQ;
	logic                   slow = 1'b0;
	logic                   rnd_on = 1'b0;
	logic [31:0]            err_addr = 32'hFFFF_FFFF;
	logic [31:0]            rs = 32'h883B;
	logic [31:0]            rs2 = 32'h883B;
	logic [65:0]            expq [$];
	logic [65:0]            n;
	logic [1:0][7:0][31:0]  dg;
	int                     fails = 0;
	int                     comparisons = 0;
	int                     ticks = 0;
	int                     cyc [2];
	int                     c, w0;
	int                     nw [3] = '{5, 8, 7};
	int                     dif [3] = '{124, 122, 122};
	imh_monitor imh_monitor_i (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HRDATA(HRDATA), .HREADY(HREADY), .HRESP(HRESP), .IRQ(IRQ));
	imh_ahb_mem imh_ahb_mem_i (.clk(CLK_SYS), .rst(RST), .haddr(HADDR),
		.htrans(HTRANS), .hwrite(HWRITE), .hwdata(HWDATA), .hrdata(HRDATA),
		.hready(HREADY), .hresp(HRESP), .slow(slow), .err_addr(err_addr));
	always #2 CLK_SYS = ~CLK_SYS;
	// ------------------------------------------------------------------
	// Bus tasks and result watcher
	// ------------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic tally_and_finish;
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [32:0] e, input logic [32:0] m);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= e[31:0];
		if (!wr)
			expq.push_back({m, e});
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do
			@(posedge CLK_SYS);
		while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK_SYS);
	endtask
	task automatic wait_irq(input int lim, output int k);
		k = 0;
		while (IRQ !== 1'b1 && k < lim)
		begin
			@(posedge CLK_SYS);
			k++;
		end
	endtask
	task automatic desc(input int w, input logic [31:0] a, f, b, nx);
		imh_ahb_mem_i.mem[w] = a;
		imh_ahb_mem_i.mem[w + 1] = f;
		imh_ahb_mem_i.mem[w + 2] = b;
		imh_ahb_mem_i.mem[w + 3] = nx;
	endtask
	task automatic fill(input int w, input int k);
		for (int i = 0; i < k; i++)
		begin
			rs = xs(rs);
			imh_ahb_mem_i.mem[w + i] = rs;
		end
	endtask
	task automatic run(input logic [31:0] f, mk, output int k);
		apb(1'b1, 12'h010, {1'b0, mk}, 33'h0);
		apb(1'b1, 12'h004, 33'h0, 33'h0);
		apb(1'b1, 12'h008, 33'h400, 33'h0);
		apb(1'b1, 12'h000, {1'b0, f}, 33'h0);
		wait_irq(20000, k);
	endtask
	// Reading status clears it, so the interrupt line must follow.
	task automatic stat(input logic [32:0] m, e);
		apb(1'b0, 12'h00C, e, m);
		@(negedge CLK_SYS);
		`CHK(IRQ, 1'b0)
	endtask
	always @(posedge CLK_SYS)
		if (PSEL && PENABLE && PREADY && !PWRITE)
		begin
			n = expq.pop_front();
			`CHK({PSLVERR, PRDATA} & n[65:33], n[32:0])
		end
	always @(posedge CLK_SYS)
	begin
		rs2 <= xs(rs2);
		slow <= rnd_on & rs2[7];
		ticks++;
		if (ticks == 90000)
		begin
			fails++;
			tally_and_finish;
		end
	end
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial
	begin
		for (int i = 0; i < 1024; i++)
			imh_ahb_mem_i.mem[i] = 32'h0;
		repeat (16) @(posedge CLK_SYS);
		RST <= 1'b0;
		@(posedge CLK_SYS);
		apb(1'b0, 12'h000, 33'h0, 33'h1_FFFF_FFFF);
		apb(1'b0, 12'h020, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
		`CHK({HSIZE, HTRANS, IRQ}, 6'h10)
		for (int g = 0; g < 3; g++)
		begin
			for (int l = 0; l < 2; l++)
			begin
				rs = 32'h883B;
				fill(12'h200, 16);
				desc(0, 32'h800, {g[1:0], l[0], 5'h02}, 0, 0);
				w0 = imh_ahb_mem_i.writes;
				run(32'h1, 32'h011, cyc[l]);
				`CHK(imh_ahb_mem_i.writes - w0, nw[g])
				stat(33'h1FFF, 33'h011);
				for (int i = 0; i < 8; i++)
					dg[l][i] = imh_ahb_mem_i.mem[256 + i];
			end
			`CHK(cyc[1] - cyc[0], dif[g])
			`CHK(dg[0], dg[1])
		end
		rnd_on <= 1'b1;
		fill(12'h200, 32);
		// secondary list gathers the second block
		desc(0, 32'h800, 32'h40, 1, 0);
		desc(4, 32'h800, 32'h42, 0, 32'h100);
		desc(64, 32'h840, 0, 0, 0);
		w0 = imh_ahb_mem_i.writes;
		run(32'h1, 32'h022, c);
		stat(33'h1FFF, 33'h033);
		for (int i = 0; i < 8; i++)
			`CHK(imh_ahb_mem_i.mem[256 + i], imh_ahb_mem_i.mem[272 + i])
		`CHK(imh_ahb_mem_i.writes - w0, 16)
		// four regions, flag disables, then a wrap to region 0
		desc(0, 32'h800, 32'h40, 0, 0);
		desc(4, 32'h800, 32'h50, 0, 0);
		desc(8, 32'h800, 32'h48, 0, 0);
		desc(12, 32'h800, 32'h40, 0, 0);
		w0 = imh_ahb_mem_i.writes;
		run(32'h1, 32'h008, c);
		stat(33'h1FFF, 33'h0DB);
		apb(1'b1, 12'h000, 33'h0, 33'h0);
		apb(1'b1, 12'h010, 33'h001, 33'h0);
		wait_irq(2000, c);
		apb(1'b0, 12'h000, 33'h0, 33'h1_FFFF_FFFF);
		`CHK(imh_ahb_mem_i.writes - w0, 40)
		for (int i = 0; i < 8; i++)
			`CHK(imh_ahb_mem_i.mem[304 + i], imh_ahb_mem_i.mem[256 + i])
		err_addr <= 32'h800;
		desc(0, 32'h800, 32'h02, 0, 0);
		run(32'h1, 32'h1000, c);
		stat(33'h1000, 33'h1000);
		err_addr <= 32'hFFFF_FFFF;
		desc(0, 32'h800, 32'h0, 0, 0);
		desc(4, 32'h840, 32'h81, 0, 0);
		w0 = imh_ahb_mem_i.writes;
		run(32'h3, 32'h300, c);
		`CHK(c, 20000)
		`CHK(imh_ahb_mem_i.writes - w0, 12)
		apb(1'b0, 12'h014, 33'h4, 33'h4);
		imh_ahb_mem_i.mem[12'h210] = ~imh_ahb_mem_i.mem[12'h210];
		wait_irq(5000, c);
		`CHK(c < 5000, 1'b1)
		stat(33'h300, 33'h200);
		`CHK(imh_ahb_mem_i.writes - w0, 12)
		apb(1'b1, 12'h000, 33'h0, 33'h0);
		`CHK(expq.size(), 0)
		tally_and_finish;
	end
endmodule
`default_nettype wire
